// file: tee_eeprom.sv
// Target-side protocol engine of a two-wire serial EEPROM.
// Assumes the serial clock and data pins are asynchronous to clk and
// that the data pin is open drain with an external pull-up.
`timescale 1ns/1ps
module tee_eeprom
    import tee_pkg::*;
#(
    parameter int WR_CYCLES = WR_CYCLES_DFLT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Strap and control inputs
    input wire logic addr_select_pin_hi,
    input wire logic addr_select_pin_mid,
    input wire logic addr_select_pin_lo,
    input wire logic write_protect,
    input wire logic [1:0] density,
    // Status
    output logic standby,
    output logic write_busy
);
    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        tee_state_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [9:0] addr;
        logic drv;
        logic host_ack;
        logic wrote;
        logic busy;
        logic [TMR_W-1:0] tmr;
    } tee_core_s;

    localparam tee_core_s RST_CORE = '{
        scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
        sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
        st: ST_IDLE, cnt: 4'h0, sh: 8'h00, addr: 10'h000,
        drv: 1'b0, host_ack: 1'b0, wrote: 1'b0, busy: 1'b0,
        tmr: '0
    };
    localparam logic [TMR_W-1:0] WR_LAST = TMR_W'(WR_CYCLES - 1);

    tee_core_s r;
    tee_core_s n;

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic dev_ok;
    logic [9:0] amask;
    logic [9:0] pmask;
    logic push_valid;
    logic push_ready;
    logic [FIFO_W-1:0] push_data;
    logic drain_valid;
    logic drain_ready;
    logic [FIFO_W-1:0] drain_data;
    logic rd_path;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_rdata;

    // Edge and bus condition detection on synchronised pins
    assign scl_rise = r.scl_s & ~r.scl_d;
    assign scl_fall = ~r.scl_s & r.scl_d;
    assign start_c = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
    assign stop_c = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
    assign amask = addr_mask(density);
    assign pmask = page_mask(density);

    // Device address compare per density
    always_comb
    begin
        dev_ok = (r.sh[7:4] == DEV_TYPE);
        case (density)
            DENS_4K:
            begin
                dev_ok = dev_ok
                    & (r.sh[SEL_HI_BIT] == addr_select_pin_hi)
                    & (r.sh[SEL_MID_BIT] == addr_select_pin_mid);
            end
            DENS_8K:
                dev_ok = dev_ok
                    & (r.sh[SEL_HI_BIT] == addr_select_pin_hi);
            default:
            begin
                dev_ok = dev_ok
                    & (r.sh[SEL_HI_BIT] == addr_select_pin_hi)
                    & (r.sh[SEL_MID_BIT] == addr_select_pin_mid)
                    & (r.sh[SEL_LO_BIT] == addr_select_pin_lo);
            end
        endcase
    end

    // Array port: reads own it while a read transfer is under way
    assign rd_path = (r.st == ST_RDATA) || (r.st == ST_RACK)
        || ((r.st == ST_ACK_DEV) && r.sh[RW_BIT]);
    assign drain_ready = ~rd_path;
    assign mem_we = drain_valid & drain_ready;
    assign mem_addr = mem_we ? drain_data[FIFO_W-1:DATA_W] : r.addr;

    // Next-state logic of the protocol engine
    always_comb
    begin
        n = r;
        push_valid = 1'b0;
        push_data = {r.addr, r.sh};
        n.scl_m = scl_in;
        n.scl_s = r.scl_m;
        n.scl_d = r.scl_s;
        n.sda_m = sda_in;
        n.sda_s = r.sda_m;
        n.sda_d = r.sda_s;

        // Self-timed write cycle counter
        if (r.busy)
        begin
            n.tmr = r.tmr + 1'b1;
            if (r.tmr == WR_LAST)
                n.busy = 1'b0;
        end

        if (start_c)
        begin
            n.st = ST_DEV;
            n.cnt = 4'h0;
            n.drv = 1'b0;
        end
        else if (stop_c)
        begin
            n.st = ST_IDLE;
            n.drv = 1'b0;
            if (r.wrote)
            begin
                n.busy = 1'b1;
                n.tmr = '0;
                n.wrote = 1'b0;
            end
        end
        else
        begin
            case (r.st)
                ST_DEV, ST_WADDR, ST_WDATA:
                begin
                    // Shift in on rise, close the word on the next fall
                    if (scl_rise && r.cnt != WORD_BITS)
                    begin
                        n.sh = {r.sh[6:0], r.sda_s};
                        n.cnt = r.cnt + 1'b1;
                    end
                    else if (scl_fall && r.cnt == WORD_BITS)
                    begin
                        n.cnt = 4'h0;
                        if (r.st == ST_DEV)
                        begin
                            if (dev_ok && !r.busy)
                            begin
                                n.st = ST_ACK_DEV;
                                n.drv = 1'b1;
                                if (density == DENS_4K)
                                    n.addr[8] = r.sh[ADDR8_POS];
                                else if (density == DENS_8K)
                                begin
                                    n.addr[8] = r.sh[ADDR8_POS];
                                    n.addr[9] = r.sh[ADDR9_POS];
                                end
                            end
                            else
                                n.st = ST_IGNORE;
                        end
                        else if (r.st == ST_WADDR)
                        begin
                            n.st = ST_ACK_WA;
                            n.drv = 1'b1;
                            n.addr = ((r.addr & ~10'h0ff) | {2'h0, r.sh})
                                & amask;
                        end
                        else if (write_protect)
                        begin
                            n.st = ST_ACK_WD;
                            n.drv = 1'b1;
                        end
                        else if (push_ready)
                        begin
                            push_valid = 1'b1;
                            n.st = ST_ACK_WD;
                            n.drv = 1'b1;
                            n.wrote = 1'b1;
                            n.addr = (r.addr & ~pmask)
                                | ((r.addr + 10'h001) & pmask);
                        end
                        else
                            n.st = ST_IGNORE;
                    end
                end
                ST_ACK_DEV:
                begin
                    // End the ack at the ninth clock fall; reads drive the first bit, writes release
                    if (scl_fall)
                    begin
                        n.cnt = 4'h0;
                        if (r.sh[RW_BIT])
                        begin
                            n.st = ST_RDATA;
                            n.sh = mem_rdata;
                            n.drv = ~mem_rdata[7];
                        end
                        else
                        begin
                            n.st = ST_WADDR;
                            n.drv = 1'b0;
                        end
                    end
                end
                ST_ACK_WA, ST_ACK_WD:
                begin
                    if (scl_fall)
                    begin
                        n.st = ST_WDATA;
                        n.drv = 1'b0;
                        n.cnt = 4'h0;
                    end
                end
                ST_RDATA:
                begin
                    // Next bit after each fall; release after the eighth
                    if (scl_fall)
                    begin
                        if (r.cnt == LAST_OUT_BIT)
                        begin
                            n.st = ST_RACK;
                            n.drv = 1'b0;
                            n.host_ack = 1'b0;
                            n.addr = (r.addr + 10'h001) & amask;
                        end
                        else
                        begin
                            n.cnt = r.cnt + 1'b1;
                            n.sh = {r.sh[6:0], 1'b0};
                            n.drv = ~r.sh[6];
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        n.host_ack = ~r.sda_s;
                    else if (scl_fall)
                    begin
                        n.cnt = 4'h0;
                        if (r.host_ack)
                        begin
                            n.st = ST_RDATA;
                            n.sh = mem_rdata;
                            n.drv = ~mem_rdata[7];
                        end
                        else
                            n.st = ST_IGNORE;
                    end
                end
                ST_IDLE, ST_IGNORE:
                    n.drv = 1'b0;
                default:
                begin
                    n.st = ST_IDLE;
                    n.drv = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= RST_CORE;
        else
            r <= n;
    end

    // Open-drain data pin: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_n = ~r.drv;

    // Status outputs
    assign write_busy = r.busy;
    assign standby = ((r.st == ST_IDLE) || (r.st == ST_IGNORE))
        & ~r.busy & ~drain_valid;

    // Write data buffer between the bus and the array
    tee_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    // Byte array
    tee_mem u_mem (
        .clk(clk),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(drain_data[DATA_W-1:0]),
        .rdata(mem_rdata)
    );

endmodule : tee_eeprom

// file: tee_pkg.sv
// Shared constants, state encoding and decode helpers for the two-wire
// serial EEPROM target. Assumes a 10 MHz system clock.
package tee_pkg;

    // Device-type pattern in the top nibble of the device address word
    localparam logic [3:0] DEV_TYPE = 4'ha;

    // Density selection codes
    localparam logic [1:0] DENS_1K = 2'h0;
    localparam logic [1:0] DENS_2K = 2'h1;
    localparam logic [1:0] DENS_4K = 2'h2;
    localparam logic [1:0] DENS_8K = 2'h3;

    // Array and data path sizes
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 1024;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = ADDR_W + DATA_W;

    // Word address masks per density and page masks
    localparam logic [9:0] MASK_1K = 10'h07f;
    localparam logic [9:0] MASK_2K = 10'h0ff;
    localparam logic [9:0] MASK_4K = 10'h1ff;
    localparam logic [9:0] MASK_8K = 10'h3ff;
    localparam logic [9:0] PAGE_SMALL = 10'h007;
    localparam logic [9:0] PAGE_LARGE = 10'h00f;

    // Bit positions in the device address word
    localparam int RW_BIT = 0;
    localparam int SEL_LO_BIT = 1;
    localparam int SEL_MID_BIT = 2;
    localparam int SEL_HI_BIT = 3;
    localparam int ADDR8_POS = 1;
    localparam int ADDR9_POS = 2;

    // Bit counting within a serial word
    localparam logic [3:0] WORD_BITS = 4'h8;
    localparam logic [3:0] LAST_OUT_BIT = 4'h7;

    // Self-timed write cycle; longest time rounds down
    localparam int CLK_PERIOD_NS = 100;
    localparam int WR_TIME_MS = 5;
    localparam int WR_CYCLES_DFLT = (WR_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TMR_W = 20;

    // Protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_ACK_DEV,
        ST_WADDR,
        ST_ACK_WA,
        ST_WDATA,
        ST_ACK_WD,
        ST_RDATA,
        ST_RACK,
        ST_IGNORE
    } tee_state_e;

    // Usable word address bits for a density
    function automatic logic [9:0] addr_mask(input logic [1:0] dens);
        case (dens)
            DENS_1K: addr_mask = MASK_1K;
            DENS_2K: addr_mask = MASK_2K;
            DENS_4K: addr_mask = MASK_4K;
            default: addr_mask = MASK_8K;
        endcase
    endfunction : addr_mask

    // Bits that advance within a page during writes
    function automatic logic [9:0] page_mask(input logic [1:0] dens);
        page_mask = dens[1] ? PAGE_LARGE : PAGE_SMALL;
    endfunction : page_mask

endpackage : tee_pkg

// file: tee_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain; data out comes from the storage registers.
`timescale 1ns/1ps
module tee_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } tee_fifo_s;

    tee_fifo_s r;
    tee_fifo_s n;
    logic push;
    logic pop;

    // Honest full and empty flags
    assign in_ready = (r.cnt != (PW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data = r.mem[r.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointer and occupancy update
    always_comb
    begin
        n = r;
        if (push)
        begin
            n.mem[r.wp] = in_data;
            n.wp = PW'((r.wp + 1'b1) % DEPTH);
        end
        if (pop)
            n.rp = PW'((r.rp + 1'b1) % DEPTH);
        if (push && !pop)
            n.cnt = r.cnt + 1'b1;
        else if (pop && !push)
            n.cnt = r.cnt - 1'b1;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= n;
    end

endmodule : tee_fifo

// file: tee_mem.sv
// Byte array of the EEPROM with one write port and a registered read.
// Assumes the owner never reads and writes the same cycle expecting both.
`timescale 1ns/1ps
module tee_mem
    import tee_pkg::*;
(
    // Clock
    input wire logic clk,
    // Access port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic we,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] cells [MEM_DEPTH];

    // Write then registered read of the addressed byte
    always_ff @(posedge clk)
    begin
        if (we)
            cells[addr] <= wdata;
        rdata <= cells[addr];
    end

endmodule : tee_mem

// file: tee_eeprom_props.sv
// Concurrent checks on the pins and status of the EEPROM target.
// Assumes one clock domain and the reset low while the bus is idle.
`timescale 1ns/1ps
module tee_eeprom_props
    import tee_pkg::*;
#(
    parameter int WR_CYCLES = 200
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // Straps and control
    input wire logic addr_select_pin_hi,
    input wire logic addr_select_pin_mid,
    input wire logic addr_select_pin_lo,
    input wire logic write_protect,
    input wire logic [1:0] density,
    // Status
    input wire logic standby,
    input wire logic write_busy
);
    typedef struct packed {
        logic [19:0] busy_cnt;
    } tee_chk_s;
    tee_chk_s st_r;
    tee_chk_s st_nxt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Length of the running write cycle
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.busy_cnt = write_busy ? st_r.busy_cnt + 20'h1 : 20'h0;
    end

    // Counter register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    a_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin output level not low");
    a_reset_idle: assert property ($rose(rst_n) |->
        sda_oe_n && !write_busy && standby)
        else $error("not idle after reset");
    a_drive_clk_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data drive changed with clock high");
    a_busy_no_ack: assert property (write_busy |-> sda_oe_n)
        else $error("data driven during write cycle");
    a_cycle_length: assert property ($fell(write_busy) |->
        st_r.busy_cnt == WR_CYCLES)
        else $error("write cycle length wrong");
    a_protect_cycle: assert property (write_protect |->
        !$rose(write_busy))
        else $error("write cycle while protected");
    a_busy_active: assert property (write_busy |-> !standby)
        else $error("standby during write cycle");
    a_cycle_stop: assert property ($rose(write_busy) |->
        scl_in && sda_in)
        else $error("write cycle not after stop");
    a_standby_quiet: assert property (standby |-> sda_oe_n)
        else $error("data driven in standby");
    a_drive_bounded: assert property ($fell(sda_oe_n) |->
        ##[1:80] sda_oe_n)
        else $error("data held low too long");
endmodule : tee_eeprom_props

bind tee_eeprom tee_eeprom_props #(.WR_CYCLES(WR_CYCLES)) u_props (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .addr_select_pin_hi(addr_select_pin_hi),
    .addr_select_pin_mid(addr_select_pin_mid),
    .addr_select_pin_lo(addr_select_pin_lo),
    .write_protect(write_protect),
    .density(density),
    .standby(standby),
    .write_busy(write_busy)
);

// file: tee_ctl_model.sv
// Two-wire bus controller model driving serial clock and data.
// Assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/1ps
module tee_ctl_model (
    // Clock
    input wire logic clk,
    // Bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // Idle bus: clock stands high between frames
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Wait n system clocks, changes land after the falling edge
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask : tk

    // Start or repeated start
    task automatic start();
        tk(1);
        sda_drv = 1'b1;
        tk(4);
        scl = 1'b1;
        tk(4);
        sda_drv = 1'b0;
        tk(4);
        scl = 1'b0;
    endtask : start

    // Stop, then leave the bus idle
    task automatic stop();
        tk(1);
        sda_drv = 1'b0;
        tk(4);
        scl = 1'b1;
        tk(4);
        sda_drv = 1'b1;
        tk(8);
    endtask : stop

    // One clock pulse: low 5, high 3; data changes in low time
    task automatic clk_bit(input logic b, output logic r);
        tk(1);
        sda_drv = b;
        tk(4);
        scl = 1'b1;
        tk(2);
        r = sda;
        tk(1);
        scl = 1'b0;
    endtask : clk_bit

    // Eight bits MSB first, then the ninth acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ai,
        output logic [7:0] rx, output logic ao);
        for (int i = 7; i >= 0; i--)
            clk_bit(tx[i], rx[i]);
        clk_bit(ai, ao);
    endtask : xfer
endmodule : tee_ctl_model

// file: two_wire_eeprom_slave_test.sv
// Self-checking bench for the EEPROM target with a reference array.
// Assumes the controller model in its own file and the bound checker.
`timescale 1ns/1ps
module two_wire_eeprom_slave_test;
    import tee_pkg::*;
    localparam int WRC = 200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda_drv, sda, sda_out, sda_oe_n, standby, write_busy;
    logic a_hi = 1'b0, a_mid = 1'b0, a_lo = 1'b0, wp = 1'b0;
    logic [1:0] dens = 2'h1;
    logic [7:0] m [0:1023];
    int n_mismatch = 0, n_compared = 0, cnt = 0;

    // Clock and wired-AND data line with pull-up
    always #50 clk = ~clk;
    assign sda = sda_drv & (sda_oe_n | sda_out);

    tee_ctl_model ctl (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
    tee_eeprom #(.WR_CYCLES(WRC)) uut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_select_pin_hi(a_hi), .addr_select_pin_mid(a_mid),
        .addr_select_pin_lo(a_lo), .write_protect(wp), .density(dens),
        .standby(standby), .write_busy(write_busy));

    function automatic logic [7:0] dev(input logic r, input int a);
        dev = {DEV_TYPE, a_hi, dens == 2'h3 ? a[9] : a_mid,
            dens[1] ? a[8] : a_lo, r};
    endfunction : dev

    function automatic int pm();
        return dens[1] ? 15 : 7;
    endfunction : pm

    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic poll();
        logic [7:0] rx;
        logic ak;
        for (int k = 0; k < 30; k++)
        begin
            ctl.start();
            ctl.xfer(dev(1'b0, 0), 1'b1, rx, ak);
            if (ak && k == 0)
                chk("busy at nack", 8'h01, {7'h0, write_busy});
            ctl.stop();
            if (!ak)
                break;
        end
        chk("poll ack", 8'h00, {7'h0, ak});
        chk("idle standby", 8'h01, {7'h0, standby});
    endtask : poll

    task automatic wr(input int a, input int n);
        logic [7:0] rx, d;
        logic ak;
        ctl.start();
        ctl.xfer(dev(1'b0, a), 1'b1, rx, ak);
        chk("dev ack", 8'h00, {7'h0, ak});
        ctl.xfer(a[7:0], 1'b1, rx, ak);
        chk("addr ack", 8'h00, {7'h0, ak});
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom);
            ctl.xfer(d, 1'b1, rx, ak);
            chk("data ack", 8'h00, {7'h0, ak});
            if (!wp)
                m[(a & ~pm()) | ((a + i) & pm())] = d;
        end
        ctl.stop();
        repeat (8) @(negedge clk);
        chk("busy", {7'h0, !wp}, {7'h0, write_busy});
        chk("standby", {7'h0, wp}, {7'h0, standby});
        poll();
    endtask : wr

    task automatic rd(input int a, input int n, input bit ran);
        logic [7:0] rx;
        logic ak;
        if (ran)
        begin
            ctl.start();
            ctl.xfer(dev(1'b0, a), 1'b1, rx, ak);
            ctl.xfer(a[7:0], 1'b1, rx, ak);
        end
        ctl.start();
        ctl.xfer(dev(1'b1, a), 1'b1, rx, ak);
        chk("read dev ack", 8'h00, {7'h0, ak});
        for (int i = 0; i < n; i++)
        begin
            ctl.xfer(8'hff, i == n - 1, rx, ak);
            chk("read data", m[(a + i) % (128 << dens)], rx);
        end
        ctl.stop();
        cnt = (a + n) % (128 << dens);
    endtask : rd

    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    // Watchdog against a hung handshake
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        results();
    end

    // Main sequence
    initial
    begin
        logic [7:0] w, rx;
        logic ak, hit;
        void'($urandom(11043));
        {a_hi, a_mid, a_lo} = 3'($urandom);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        wr(10'h05a, 1);
        rd(10'h05a, 1, 1'b1);
        dens = 2'h0;
        wr(10'h07e, 4);
        rd(10'h078, 2, 1'b1);
        $display("test 1 done");
        dens = 2'h2;
        wr(10'h1f5, 18);
        rd(10'h1f0, 15, 1'b1);
        rd(cnt, 1, 1'b0);
        $display("test 2 done");
        dens = 2'h3;
        wr(10'h3f8, 8);
        wr(10'h000, 4);
        rd(10'h3fe, 4, 1'b1);
        $display("test 3 done");
        wp = 1'b1;
        wr(10'h3f8, 2);
        wp = 1'b0;
        rd(10'h3f8, 2, 1'b1);
        $display("test 4 done");
        ctl.start();
        ctl.xfer(dev(1'b1, 10'h3fc), 1'b1, rx, ak);
        repeat (3) ctl.clk_bit(1'b1, ak);
        ctl.start();
        repeat (9) ctl.clk_bit(1'b1, ak);
        ctl.start();
        ctl.stop();
        chk("released", 8'h01, {7'h0, sda_oe_n});
        rd(10'h3fc, 2, 1'b1);
        $display("test 5 done");
        for (int i = 0; i < 16; i++)
        begin
            w = 8'($urandom) & 8'hfe;
            if (i[0])
                w[7:4] = DEV_TYPE;
            {a_hi, a_mid, a_lo} = 3'($urandom);
            dens = 2'(i / 4);
            hit = w[7:4] == DEV_TYPE && w[3] == a_hi;
            hit = hit && (dens == 2'h3 || w[2] == a_mid);
            hit = hit && (dens[1] || w[1] == a_lo);
            ctl.start();
            ctl.xfer(w, 1'b1, rx, ak);
            chk("match ack", {7'h0, !hit}, {7'h0, ak});
            if (!hit)
            begin
                ctl.xfer(8'h00, 1'b1, rx, ak);
                chk("ignored", 8'h01, {7'h0, ak});
            end
            ctl.stop();
        end
        $display("test 6 done");
        results();
    end
endmodule : two_wire_eeprom_slave_test
